// ===== rtl/logic_cluster.sv
// Overview of operation
// - cluster holds exactly ten logic elements
// - 26 external inputs plus 10 feedback lines
// - lut output chains to next element
// - register output chains to next register
// - routing fed by row, column, self, neighbours
// - each element reaches thirty other elements
// - ten cluster control signals generated here
// - each clock paired with its enable
// - dual edge: clock two taken from the falling edge of clock one
// - enable low stops the paired clock
// - preset made by async load of one
// - one add/subtract select for all elements
// - controls from column clocks or routing
// - global lines usable as clear or enable
// - four-input lut, any function
// - register and carry-select chain per element
// - 8192-bit user store, read and written
// - configuration loaded from reset image automatically
// - register types d, t, jk, sr
// - subtract inverts b, carry-in one
//
// The placing of the registers and register access over APB were decided locally.
module logic_cluster
    import cluster_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NUM_GCLK-1:0] gclk_pin,
    input  wire logic [NUM_EXT-1:0]  ext_in,
    input  wire logic [NUM_ELEM-1:0] left_link_in,
    input  wire logic [NUM_ELEM-1:0] right_link_in,
    output logic      [NUM_ELEM-1:0] route_out,
    output logic                     route_oe,
    output logic      [NUM_ELEM-1:0] link_out
);

    // pool bit picker, 0 beyond the pool
    function automatic logic pick(input logic [POOL_W-1:0] p, input logic [5:0] s);
        pick = (s < 6'(POOL_W)) ? p[s] : 1'b0;
    endfunction

    logic [NUM_GCLK-1:0] gclk_meta;   // first sync stage
    logic [NUM_GCLK-1:0] gclk_sync;   // second sync stage
    logic [NUM_EXT-1:0]  ext_meta;
    logic [NUM_EXT-1:0]  ext_sync;

    elem_mode_t  mode_reg  [NUM_ELEM];  // element modes
    elem_route_t route_reg [NUM_ELEM];  // element input selects
    ctrl_cfg_t   ctrl_reg  [NUM_CTRL];  // control sources
    gcfg_t       gcfg_reg;
    logic        configured_reg;        // set once the image is live
    logic [31:0] store_mem [STORE_WORDS];  // user store words

    logic [NUM_ELEM-1:0] out_reg;       // element outputs, registered
    logic                oe_reg;
    logic [POOL_W-1:0]   pool;          // local routing sources
    logic [NUM_CTRL-1:0] ctrl_lvl;      // control levels
    logic [1:0]          clk_prev_reg;  // last clock levels
    logic [1:0]          ena;
    logic                rise0;
    logic                fall0;
    logic                rise1;
    ctrl_bus_t           cbus;
    elem_out_t           eo [NUM_ELEM];

    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        hit_mode;
    logic        hit_route;
    logic        hit_ctrl;
    logic        hit_gcfg;
    logic        hit_status;
    logic        hit_store;
    logic        addr_err;
    logic [3:0]  idx;
    logic [11:0] ctrl_ofs;
    logic [31:0] rdata;
    logic        xfer_done;
    logic        wr_en;
    logic [31:0] status_word;

    // pins pass two flops; only stage two is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gclk_meta <= '0;
            gclk_sync <= '0;
            ext_meta  <= '0;
            ext_sync  <= '0;
        end else begin
            gclk_meta <= gclk_pin;
            gclk_sync <= gclk_meta;
            ext_meta  <= ext_in;
            ext_sync  <= ext_meta;
        end
    end

    // 26 inputs plus 10 registered feedback lines
    // neighbours left and right feed the pool too
    // column clocks sit at the top of the pool
    // feedback is registered so no config can close a combinational loop
    assign pool = {gclk_sync, right_link_in, left_link_in, out_reg, ext_sync};

    // ten control levels, each from pool
    // global lines usable as clear or preset
    always_comb begin
        for (int k = 0; k < NUM_CTRL; k++) begin
            ctrl_lvl[k] = ctrl_reg[k].use_en &
                          (pick(pool, ctrl_reg[k].src) ^ ctrl_reg[k].invert);
        end
    end

    // previous clock levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_reg <= 2'b00;
        end else begin
            clk_prev_reg <= ctrl_lvl[CTL_CLK2:CTL_CLK1];
        end
    end

    // unused enable reads as always enabled
    assign ena[0] = ctrl_reg[CTL_ENA1].use_en ? ctrl_lvl[CTL_ENA1] : 1'b1;
    assign ena[1] = ctrl_reg[CTL_ENA2].use_en ? ctrl_lvl[CTL_ENA2] : 1'b1;
    assign rise0  = ctrl_lvl[CTL_CLK1] & ~clk_prev_reg[0];
    assign fall0  = ~ctrl_lvl[CTL_CLK1] & clk_prev_reg[0];
    assign rise1  = ctrl_lvl[CTL_CLK2] & ~clk_prev_reg[1];

    // clock one gated by enable one
    // enable low switches the clock off
    assign cbus.tick[0] = rise0 & ena[0];
    // dual edge spends clock two on the falling edge
    assign cbus.tick[1] = (gcfg_reg.dual_edge ? fall0 : rise1) & ena[1];
    assign cbus.aclr    = {ctrl_lvl[CTL_ACLR2], ctrl_lvl[CTL_ACLR1]};
    assign cbus.aload   = ctrl_lvl[CTL_ALOAD];
    // sync clear and load go to every element
    assign cbus.sclr    = ctrl_lvl[CTL_SCLR];
    assign cbus.sload   = ctrl_lvl[CTL_SLOAD];
    // one add/subtract select for the cluster
    assign cbus.sub_sel = ctrl_lvl[CTL_SUB];

    for (genvar i = 0; i < NUM_ELEM; i++) begin : g_elem
        logic [3:0] din;    // selected data inputs
        logic       lchain;
        logic       rchain;
        logic       cin;
        assign din = {pick(pool, route_reg[i].sel_d), pick(pool, route_reg[i].sel_c),
                      pick(pool, route_reg[i].sel_b), pick(pool, route_reg[i].sel_a)};
        if (i == 0) begin : g_first
            assign lchain = 1'b0;
            assign rchain = 1'b0;
            // first carry-in forced to one on subtract
            assign cin    = mode_reg[0].arith & cbus.sub_sel;
        end else begin : g_rest
            assign lchain = eo[i-1].lut;
            assign rchain = eo[i-1].q;
            assign cin    = eo[i-1].carry;
        end
        logic_element u_elem (
            .pclk         (pclk),
            .presetn      (presetn),
            .mode         (mode_reg[i]),
            .data         (din),
            .lut_chain_in (lchain),
            .reg_chain_in (rchain),
            .carry_in     (cin),
            .ctrl         (cbus),
            .eo           (eo[i])
        );
    end

    // outputs drive local, left and right clusters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= '0;
            oe_reg  <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_ELEM; i++) begin
                out_reg[i] <= eo[i].out;
            end
            // output enable may come from a global line
            oe_reg <= gcfg_reg.oe_use ? pick(pool, gcfg_reg.oe_src) : 1'b1;
        end
    end

    assign route_out = out_reg;
    assign link_out  = out_reg;
    assign route_oe  = oe_reg;

    // address decode, shared by read and write
    assign ctrl_ofs = paddr - ADDR_CTRL_BASE;
    always_comb begin
        hit_mode   = 1'b0;
        hit_route  = 1'b0;
        hit_ctrl   = 1'b0;
        hit_gcfg   = 1'b0;
        hit_status = 1'b0;
        hit_store  = 1'b0;
        idx        = 4'h0;
        if (paddr[1:0] != 2'b00) begin
            idx = 4'h0;
        end else if (paddr < ADDR_CTRL_BASE) begin
            idx       = paddr[6:3];
            hit_mode  = ~paddr[2];
            hit_route = paddr[2];
        end else if (paddr < ADDR_GCFG) begin
            idx      = ctrl_ofs[5:2];
            hit_ctrl = 1'b1;
        end else if (paddr == ADDR_GCFG) begin
            hit_gcfg = 1'b1;
        end else if (paddr == ADDR_STATUS) begin
            hit_status = 1'b1;
        end else if (paddr >= ADDR_STORE_BASE && paddr <= ADDR_STORE_END) begin
            hit_store = 1'b1;
        end
    end
    assign addr_err = ~(hit_mode | hit_route | hit_ctrl | hit_gcfg | hit_status | hit_store);

    // live status of the cluster
    always_comb begin
        status_word = '0;
        for (int i = 0; i < NUM_ELEM; i++) begin
            status_word[i]            = eo[i].q;
            status_word[NUM_ELEM + i] = eo[i].lut;
        end
        status_word[2*NUM_ELEM]     = configured_reg;
        status_word[2*NUM_ELEM + 1] = eo[NUM_ELEM-1].carry;
    end

    // read mux
    always_comb begin
        rdata = '0;
        if (hit_mode) begin
            rdata = {8'h00, mode_reg[idx]};
        end else if (hit_route) begin
            rdata = {8'h00, route_reg[idx]};
        end else if (hit_ctrl) begin
            rdata = {24'h000000, ctrl_reg[idx]};
        end else if (hit_gcfg) begin
            rdata = {24'h000000, gcfg_reg};
        end else if (hit_status) begin
            rdata = status_word;
        end else if (hit_store) begin
            rdata = store_mem[paddr[9:2]];
        end
    end

    // one wait state: ready rises on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else if (psel && penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= addr_err;
            prdata_reg  <= (pwrite || addr_err) ? 32'h00000000 : rdata;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign xfer_done = psel & penable & pready_reg;
    assign wr_en     = xfer_done & pwrite & ~pslverr_reg;

    // reset image is the power-up configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_ELEM; i++) begin
                mode_reg[i]  <= ELEM_MODE_RST;
                route_reg[i] <= ELEM_ROUTE_RST;
            end
        end else if (wr_en && hit_mode) begin
            mode_reg[idx] <= pwdata[23:0];
        end else if (wr_en && hit_route) begin
            route_reg[idx] <= pwdata[23:0];
        end
    end

    // control source and cluster option writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NUM_CTRL; k++) begin
                ctrl_reg[k] <= CTRL_RST;
            end
            gcfg_reg <= GCFG_RST;
        end else if (wr_en && hit_ctrl) begin
            ctrl_reg[idx] <= pwdata[7:0];
        end else if (wr_en && hit_gcfg) begin
            gcfg_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            configured_reg <= 1'b0;
        end else begin
            configured_reg <= 1'b1;
        end
    end

    // user store, kept out of reset like flash
    always_ff @(posedge pclk) begin
        if (wr_en && hit_store) begin
            store_mem[paddr[9:2]] <= pwdata;
        end
    end

endmodule

// ===== rtl/cluster_pkg.sv
package cluster_pkg;

    // cluster geometry
    localparam int NUM_ELEM    = 10;   // logic elements per cluster
    localparam int NUM_EXT     = 26;   // distinct external inputs
    localparam int NUM_GCLK    = 4;    // global clock lines
    localparam int NUM_CTRL    = 10;   // cluster-wide control signals
    localparam int POOL_W      = 60;   // ext + feedback + left + right + gclk
    localparam int STORE_WORDS = 256;  // 8192 bits of user store

    // control signal slots
    localparam int CTL_CLK1  = 0;
    localparam int CTL_CLK2  = 1;
    localparam int CTL_ENA1  = 2;
    localparam int CTL_ENA2  = 3;
    localparam int CTL_ACLR1 = 4;
    localparam int CTL_ACLR2 = 5;
    localparam int CTL_SCLR  = 6;
    localparam int CTL_ALOAD = 7;
    localparam int CTL_SLOAD = 8;
    localparam int CTL_SUB   = 9;

    // register map, byte addresses
    localparam logic [11:0] ADDR_ELEM_BASE  = 12'h000;
    localparam logic [11:0] ADDR_CTRL_BASE  = 12'h050;
    localparam logic [11:0] ADDR_GCFG       = 12'h078;
    localparam logic [11:0] ADDR_STATUS     = 12'h07c;
    localparam logic [11:0] ADDR_STORE_BASE = 12'h400;
    localparam logic [11:0] ADDR_STORE_END  = 12'h7fc;

    // register flip-flop types
    typedef enum logic [1:0] {REG_D, REG_T, REG_JK, REG_SR} reg_type_t;

    // per-element mode word
    typedef struct packed {
        logic       clr_sel;       // which async clear
        logic       out_reg;       // output from register, else lut
        logic       arith;         // arithmetic mode
        logic       reg_chain_en;  // register d from previous register
        logic       lut_chain_en;  // lut input d from previous lut
        logic       clk_sel;       // cluster clock one or two
        reg_type_t  reg_type;
        logic [15:0] mask;         // lut truth table
    } elem_mode_t;

    // per-element input selects into the routing pool
    typedef struct packed {
        logic [5:0] sel_d;
        logic [5:0] sel_c;
        logic [5:0] sel_b;
        logic [5:0] sel_a;
    } elem_route_t;

    // one control signal source
    typedef struct packed {
        logic       use_en;
        logic       invert;
        logic [5:0] src;
    } ctrl_cfg_t;

    // cluster-wide options
    typedef struct packed {
        logic       dual_edge;  // clock two = falling edge of clock one source
        logic       oe_use;
        logic [5:0] oe_src;
    } gcfg_t;

    // control bundle to every element
    typedef struct packed {
        logic [1:0] tick;      // gated cluster clock edges
        logic [1:0] aclr;
        logic       aload;
        logic       sclr;
        logic       sload;
        logic       sub_sel;   // high = subtract
    } ctrl_bus_t;

    // element outputs
    typedef struct packed {
        logic lut;
        logic q;
        logic out;
        logic carry;
    } elem_out_t;

    // reset images, the power-up configuration
    localparam elem_mode_t  ELEM_MODE_RST  = 24'h000000;
    localparam elem_route_t ELEM_ROUTE_RST = 24'h000000;
    localparam ctrl_cfg_t   CTRL_RST       = 8'h00;
    localparam gcfg_t       GCFG_RST       = 8'h00;

endpackage

// ===== rtl/logic_element.sv
module logic_element
    import cluster_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire elem_mode_t  mode,
    input  wire logic [3:0]  data,
    input  wire logic        lut_chain_in,
    input  wire logic        reg_chain_in,
    input  wire logic        carry_in,
    input  wire ctrl_bus_t   ctrl,
    output elem_out_t        eo
);

    logic d3;       // lut input d after chain mux
    logic b_eff;    // second operand after add/sub
    logic s0;       // sum if carry-in is 0
    logic s1;       // sum if carry-in is 1
    logic co0;      // carry-out if carry-in is 0
    logic co1;      // carry-out if carry-in is 1
    logic lut_val;  // lut or arithmetic result
    logic d_in;     // register data input
    logic tick;     // this element's clock edge
    logic aclr;     // this element's async clear
    logic q_reg;
    logic q_next;
    logic q_eff;

    assign d3 = mode.lut_chain_en ? lut_chain_in : data[3];

    assign b_eff = data[1] ^ ctrl.sub_sel;

    assign s0  = data[0] ^ b_eff;
    assign s1  = ~s0;
    assign co0 = data[0] & b_eff;
    assign co1 = data[0] | b_eff;

    assign lut_val = mode.arith ? (carry_in ? s1 : s0)
                                : mode.mask[{d3, data[2], data[1], data[0]}];

    assign d_in = mode.reg_chain_en ? reg_chain_in : lut_val;

    assign tick = ctrl.tick[mode.clk_sel];
    assign aclr = ctrl.aclr[mode.clr_sel];

    // next state per register type, then sync clear/load
    always_comb begin
        q_next = q_reg;
        case (mode.reg_type)
            REG_D:  q_next = d_in;
            REG_T:  q_next = q_reg ^ d_in;
            REG_JK: q_next = (d_in & ~q_reg) | (~data[2] & q_reg);
            // set wins when both set and reset are high
            REG_SR: q_next = d_in | (~data[2] & q_reg);
            default: q_next = q_reg;
        endcase
        if (ctrl.sclr) begin
            q_next = 1'b0;
        end else if (ctrl.sload) begin
            q_next = data[2];
        end
    end

    // register; async clear beats everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= 1'b0;
        end else if (aclr) begin
            q_reg <= 1'b0;
        end else if (ctrl.aload) begin
            q_reg <= data[3];
        // no edge while enable is low
        end else if (tick) begin
            q_reg <= q_next;
        end
    end

    // clear shows at once, not at the edge
    assign q_eff = aclr ? 1'b0 : (ctrl.aload ? data[3] : q_reg);

    assign eo.lut   = lut_val;
    assign eo.q     = q_eff;
    assign eo.out   = mode.out_reg ? q_eff : lut_val;
    assign eo.carry = carry_in ? co1 : co0;

endmodule

// ===== dv/logic_cluster_chk.sv
module logic_cluster_chk
    import cluster_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [NUM_ELEM-1:0] route_out,
    input wire logic                route_oe,
    input wire logic [NUM_ELEM-1:0] link_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first access cycle of a transfer
    sequence s_first_access;
        psel && penable && !$past(penable);
    endsequence
    // one wait state, then a one-cycle answer
    sequence s_answer;
        !pready ##1 pready ##1 !pready;
    endsequence
    chk_wait_state: assert property (s_first_access |-> s_answer)
        else $error("apb answer not after one wait state");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    chk_err_misalign: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    chk_err_unmapped: assert property (pready && paddr inside {[12'h080:12'h3ff]} |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && paddr[1:0] == 2'b00
        && (paddr < 12'h080 || paddr inside {[ADDR_STORE_BASE:ADDR_STORE_END]}) |-> !pslverr)
        else $error("mapped access refused");
    // a refused read must not leak stale data
    chk_err_zero_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_data_hold: assert property ($changed(prdata) |-> pready)
        else $error("prdata moved without an answer");
    chk_link_mirror: assert property (link_out == route_out)
        else $error("link out differs from route out");
    chk_oe_release: assert property ($rose(presetn) |-> ##[0:2] route_oe)
        else $error("output enable not up after reset");
    // reset is asynchronous, so this one must stay armed during it
    chk_reset_quiet: assert property (disable iff (1'b0) !presetn
        |-> route_out == '0 && !route_oe && !pready)
        else $error("outputs active in reset");
endmodule

bind logic_cluster logic_cluster_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .route_out(route_out), .route_oe(route_oe), .link_out(link_out)
);

// ===== dv/cluster_nbr_model.sv
module cluster_nbr_model
    import cluster_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [NUM_ELEM-1:0] link_out,
    input  wire logic [NUM_ELEM-1:0] left_pat,
    input  wire logic [NUM_GCLK-1:0] gclk_req,
    output logic      [NUM_ELEM-1:0] left_link_in,
    output logic      [NUM_ELEM-1:0] right_link_in,
    output logic      [NUM_GCLK-1:0] gclk_pin
);
    // neighbours are registered clusters on our clock, so links change only at edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_link_in  <= '0;
            right_link_in <= '0;
            gclk_pin      <= '0;
        end else begin
            // left neighbour plays its own pattern
            left_link_in  <= left_pat;
            // right neighbour echoes our link inverted, a live feedback path
            right_link_in <= ~link_out;
            // global clock buffer, one flop of skew
            gclk_pin      <= gclk_req;
        end
    end
endmodule

// ===== dv/logic_cluster_tb_top.sv
module logic_cluster_tb_top
    import cluster_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // expected apb answer, only mask bits compared
    typedef struct packed {
        logic        err;
        logic [31:0] data;
        logic [31:0] mask;
    } note_t;
    // shift test steps: {a, enable, q2, q1}
    localparam logic [3:0] STEPS [5] = '{4'hd, 4'h6, 4'ha, 4'hd, 4'hf};
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, route_oe;
    logic [11:0]         paddr, a;
    logic [31:0]         pwdata, prdata, seed, m;
    logic [NUM_GCLK-1:0] gclk_pin, gclk_req;
    logic [NUM_EXT-1:0]  ext_in;
    logic [NUM_ELEM-1:0] left_link_in, right_link_in, route_out, link_out, left_pat;
    note_t               notes [$];
    int                  num_errors;
    int                  checks;

    logic_cluster uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gclk_pin(gclk_pin), .ext_in(ext_in), .left_link_in(left_link_in),
        .right_link_in(right_link_in), .route_out(route_out), .route_oe(route_oe),
        .link_out(link_out)
    );
    cluster_nbr_model nbr (
        .pclk(pclk), .presetn(presetn), .link_out(link_out), .left_pat(left_pat),
        .gclk_req(gclk_req), .left_link_in(left_link_in), .right_link_in(right_link_in),
        .gclk_pin(gclk_pin)
    );

    // 250 mhz
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        num_errors++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // x/unknown on a masked bit never passes
    task automatic cmp_apb(input note_t n);
        checks++;
        if (pslverr !== n.err || ((prdata ^ n.data) & n.mask) !== 32'h0) fail("apb answer");
    endtask
    task automatic cmp_route(input logic [NUM_ELEM-1:0] mk, input logic [NUM_ELEM-1:0] e);
        checks++;
        if ((route_out & mk) !== e) fail("route out");
    endtask
    // apb master: note first, hold until pready seen, release at that edge
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
                        input logic e, input logic [31:0] x, input logic [31:0] mk);
        int n;
        notes.push_back('{e, x, mk});
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("apb timeout");
            results();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d, 1'b0, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] x, input logic [31:0] mk);
        xfer(1'b0, ad, 32'h0, 1'b0, x, mk);
    endtask
    // one global clock edge, long enough to pass the pin synchroniser
    task automatic pulse();
        gclk_req[0] <= 1'b1;
        tick(4);
        gclk_req[0] <= 1'b0;
        tick(4);
    endtask
    // answer monitor, takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            if (notes.size() == 0) fail("unexpected answer");
            else cmp_apb(notes.pop_front());
        end
    end

    initial begin
        #1 {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_in, left_pat, gclk_req} = '0;
        seed = 32'hec1cfe20;
        num_errors = 0;
        checks = 0;
        tick(2);
        cmp_route(10'h3ff, 10'h000);
        tick(2);
        presetn <= 1'b1;
        rd(ADDR_STATUS, 32'h100000, 32'h1fffff);
        // store words back to back, top word included
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = (i == 0) ? ADDR_STORE_END : ADDR_STORE_BASE | {2'b00, seed[7:0], 2'b00};
            seed = lfsr(seed);
            wr(a, seed);
            rd(a, seed, 32'hffffffff);
        end
        // refusals and an accepted status write leave the store untouched
        wr(ADDR_STORE_BASE, 32'h5a5a0f0f);
        xfer(1'b1, 12'h402, 32'hffffffff, 1'b1, 32'h0, 32'h0);
        xfer(1'b0, 12'h100, 32'h0, 1'b1, 32'h0, 32'hffffffff);
        wr(ADDR_STATUS, 32'hffffffff);
        rd(ADDR_STORE_BASE, 32'h5a5a0f0f, 32'hffffffff);
        // element 0 lut on ext0, left0, ext2, ext3
        seed = lfsr(seed);
        m = {16'h0, seed[15:0]};
        wr(ADDR_ELEM_BASE, m);
        rd(ADDR_ELEM_BASE, m, 32'hffffffff);
        wr(ADDR_ELEM_BASE + 12'h4, {8'h0, 6'd3, 6'd2, 6'd36, 6'd0});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            ext_in[3:0] <= seed[3:0];
            left_pat[0] <= seed[4];
            tick(5);
            cmp_route(10'h001, {9'h0, m[{ext_in[3:2], left_link_in[0], ext_in[0]}]});
        end
        // element 1 registers ext4, element 2 chains it; clock gclk0, enable ext5
        wr(ADDR_ELEM_BASE + 12'h8, 32'h40aaaa);
        wr(ADDR_ELEM_BASE + 12'hc, {8'h0, 6'd8, 12'h0, 6'd4});
        wr(ADDR_ELEM_BASE + 12'h10, 32'h500000);
        wr(ADDR_CTRL_BASE, 32'hb8);
        wr(ADDR_CTRL_BASE + 12'h8, 32'h85);
        wr(ADDR_CTRL_BASE + 12'h10, 32'hb9);
        for (int i = 0; i < 5; i++) begin
            ext_in[5:4] <= {STEPS[i][2], STEPS[i][3]};
            tick(3);
            pulse();
            cmp_route(10'h006, {7'h0, STEPS[i][1:0], 1'b0});
        end
        rd(ADDR_STATUS, 32'h100006, 32'h100006);
        // async clear from global line 1 beats the clock
        gclk_req[1] <= 1'b1;
        tick(5);
        cmp_route(10'h006, 10'h000);
        pulse();
        cmp_route(10'h006, 10'h000);
        gclk_req[1] <= 1'b0;
        // preset through async load of a one on ext8
        wr(ADDR_CTRL_BASE + 12'h1c, 32'h87);
        ext_in[8:7] <= 2'b11;
        tick(5);
        cmp_route(10'h002, 10'h002);
        ext_in[7] <= 1'b0;
        // sync clear waits for the enable
        wr(ADDR_CTRL_BASE + 12'h18, 32'h89);
        ext_in[9:5] <= 5'b11000;
        tick(3);
        pulse();
        cmp_route(10'h002, 10'h002);
        ext_in[5] <= 1'b1;
        tick(3);
        pulse();
        cmp_route(10'h006, 10'h000);
        // element 0 subtract, low bit
        wr(ADDR_ELEM_BASE, 32'h200000);
        wr(ADDR_ELEM_BASE + 12'h4, 32'h40);
        wr(ADDR_CTRL_BASE + 12'h24, 32'hff);
        tick(2);
        cmp_route(10'h001, {9'h0, ext_in[0] ^ ext_in[1]});
        tick(2);
        results();
    end
endmodule
